/* File: core/sfsr_defs.svh */
// Purpose: Constants of the serial flash status read block
// Assumes: Included by bare name from core files
// Notes: Bit positions are indexes into an 8-bit status byte
// Function
// R1 - A read starts with chip select low and the status opcode shifted in
// R2 - A status read is served at any time, also while busy
// R3 - After the last opcode bit one status bit leaves per clock
// R4 - After byte two the stream restarts at byte one while selected
// R5 - Status is sampled live per byte; ready flag is in both bytes
// R6 - Chip select high ends the read and floats the output, any bit
// R7 - Top bit of each byte is 0 while busy, 1 when ready
// R8 - Byte one bit 6 holds the most recent compare mismatch result
// R9 - Byte one bits 5 to 2 return a fixed legacy density code
// R10 - Byte one bit 1 is 1 when software or hardware protection is on
// R11 - Byte one bit 0 is 0 for extended pages, 1 for binary pages
// R12 - Byte two bits 6 and 4 always read 0
// R13 - Byte two bit 5 is 1 when the last erase or program failed
// R14 - Byte two bit 3 is 1 while sector lockdown remains enabled
// R15 - Byte two bit 2 is 1 while a buffer two program is suspended
// R16 - Byte two bit 1 is 1 while a buffer one program is suspended
// R17 - Byte two bit 0 is 1 while some erase is suspended
// R18 - Host keeps clocking status until ready goes from 0 to 1
// R19 - Error flag updated per operation, set on failure, clear on abort
// R20 - Bytes leave most significant bit first on the falling clock edge
`ifndef SFSR_DEFS_SVH
`define SFSR_DEFS_SVH

`define SFSR_OP_STATUS_READ 8'hd7
`define SFSR_LAST_BIT 3'h7
`define SFSR_BIT_READY 7
`define SFSR_B1_COMPARE 6
`define SFSR_B1_DENS_HI 5
`define SFSR_B1_DENS_LO 2
`define SFSR_B1_PROTECT 1
`define SFSR_B1_PAGE 0
`define SFSR_B2_RSV_HI 6
`define SFSR_B2_ERROR 5
`define SFSR_B2_RSV_LO 4
`define SFSR_B2_LOCKDOWN 3
`define SFSR_B2_PS2 2
`define SFSR_B2_PS1 1
`define SFSR_B2_ERASE_SUSP 0
`define SFSR_RST_COMPARE 1'b0
`define SFSR_RST_ERROR 1'b0
`define SFSR_RST_LOCKDOWN 1'b1
`define SFSR_RST_BYTE 8'h00

`endif

/* File: core/sfsr_if.sv */
// Purpose: Carrier between the status core and the link shifter
// Assumes: Both ends sit in the serial clock domain
// Notes: No clocking block
`timescale 1ns/1ns
`default_nettype none
interface sfsr_if;
    import sfsr_pkg::*;
    sfsr_byte_t byte_one;
    sfsr_byte_t byte_two;
    logic so;
    logic so_oe_n;
    logic served_toggle;

    modport core (
        output byte_one,
        output byte_two,
        input so,
        input so_oe_n,
        input served_toggle
    );

    modport shift (
        input byte_one,
        input byte_two,
        output so,
        output so_oe_n,
        output served_toggle
    );
endinterface
`default_nettype wire

/* File: core/sfsr_link_shifter.sv */
// Purpose: Serial opcode decode and status byte shifter
// Assumes: SPI mode 0 or 3; input sampled rising, output driven falling
// Notes: Link reset is chip select high or system reset
`timescale 1ns/1ns
`default_nettype none
`include "sfsr_defs.svh"
module sfsr_link_shifter
    import sfsr_pkg::*;
(
    input wire logic sck_i,
    input wire logic link_rst_i,
    input wire logic sys_rst_i,
    input wire logic si_i,
    sfsr_if.shift lnk
);
    sfsr_link_state_e state;
    logic [2:0] in_cnt;
    logic [6:0] op_sr;
    logic [2:0] out_cnt;
    logic second_byte;
    logic [6:0] tx_sr;
    logic op_hit;
    logic op_last;
    sfsr_byte_t cur_byte;

    assign op_hit = ({op_sr, si_i} == `SFSR_OP_STATUS_READ); // R1
    assign op_last = (state == SFSR_LS_OPCODE) && (in_cnt == `SFSR_LAST_BIT);
    assign cur_byte = second_byte ? lnk.byte_two : lnk.byte_one; // R4

    // Opcode capture
    always_ff @(posedge sck_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            state <= SFSR_LS_OPCODE; // R6
            in_cnt <= 3'h0;
            op_sr <= 7'h00;
        end else begin
            case (state)
                SFSR_LS_OPCODE: begin
                    in_cnt <= in_cnt + 3'h1;
                    op_sr <= {op_sr[5:0], si_i};
                    if (op_last) begin
                        state <= op_hit ? SFSR_LS_STATUS : SFSR_LS_IGNORE; // R1
                    end
                end
                SFSR_LS_STATUS: state <= SFSR_LS_STATUS; // R2
                SFSR_LS_IGNORE: state <= SFSR_LS_IGNORE;
                default: state <= SFSR_LS_OPCODE;
            endcase
        end
    end

    // Served-read event; survives chip select
    always_ff @(posedge sck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lnk.served_toggle <= 1'b0;
        end else if (op_last && op_hit) begin
            lnk.served_toggle <= ~lnk.served_toggle;
        end
    end

    // Output shifting
    always_ff @(negedge sck_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            out_cnt <= 3'h0;
            second_byte <= 1'b0;
            tx_sr <= 7'h00;
            lnk.so <= 1'b0;
            lnk.so_oe_n <= 1'b1; // R6
        end else if (state == SFSR_LS_STATUS) begin
            lnk.so_oe_n <= 1'b0; // R3
            out_cnt <= out_cnt + 3'h1;
            if (out_cnt == 3'h0) begin
                lnk.so <= cur_byte[7]; // R20 R5
                tx_sr <= cur_byte[6:0];
            end else begin
                lnk.so <= tx_sr[6]; // R20
                tx_sr <= {tx_sr[5:0], 1'b0};
            end
            if (out_cnt == `SFSR_LAST_BIT) begin
                second_byte <= ~second_byte; // R4
            end
        end
    end
endmodule
`default_nettype wire

/* File: core/sfsr_pkg.sv */
// Purpose: Types of the serial flash status read block
// Assumes: Constants live in sfsr_defs.svh
// Notes: Types only
package sfsr_pkg;

    typedef enum logic [1:0] {
        SFSR_LS_OPCODE,
        SFSR_LS_STATUS,
        SFSR_LS_IGNORE
    } sfsr_link_state_e;

    typedef struct packed {
        logic ready;
        logic compare_mismatch;
        logic protect;
        logic binary_page;
        logic erase_program_error_flag;
        logic lockdown_enable_flag;
        logic buffer_two_program_suspended;
        logic buffer_one_program_suspended;
        logic erase_suspended_flag;
    } sfsr_flags_s;

    typedef logic [7:0] sfsr_byte_t;

endpackage

/* File: core/sfsr_status_top.sv */
// Purpose: Two-byte status register and its serial read command
// Assumes: clock_i 10 MHz system clock; sck_i is the serial link clock
// Notes: Status flags cross to the link as independent levels
`timescale 1ns/1ns
`default_nettype none
`include "sfsr_defs.svh"
module sfsr_status_top
    import sfsr_pkg::*;
#(
    // Arbitrary value
    parameter logic [3:0] DENSITY_CODE = 4'h5
)
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_n_o,
    input wire logic busy_i,
    input wire logic compare_done_i,
    input wire logic compare_mismatch_i,
    input wire logic protect_sw_i,
    input wire logic protect_hw_i,
    input wire logic binary_page_i,
    input wire logic op_done_i,
    input wire logic op_fail_i,
    input wire logic op_abort_i,
    input wire logic lockdown_disable_i,
    input wire logic buffer_two_program_suspended_i,
    input wire logic buffer_one_program_suspended_i,
    input wire logic erase_suspended_i,
    output logic [7:0] status_byte_one_o,
    output logic [7:0] status_byte_two_o,
    output logic read_active_o,
    output logic [7:0] status_reads_o
);
    localparam int FLAG_W = $bits(sfsr_flags_s);

    sfsr_if lnk ();

    logic link_rst;
    logic ready;
    logic compare_mismatch;
    logic protect;
    logic binary_page;
    logic erase_program_error_flag;
    logic lockdown_enable_flag;
    logic ps2;
    logic ps1;
    logic erase_susp;
    sfsr_flags_s sys_flags;
    logic [FLAG_W-1:0] flag_vec;
    logic [FLAG_W-1:0] flag_meta;
    logic [FLAG_W-1:0] flag_mid;
    logic [FLAG_W-1:0] flag_late;
    logic [FLAG_W-1:0] flag_link;
    sfsr_flags_s link_flags;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic tog_seen;

    function automatic sfsr_byte_t sfsr_compose_one(
        input sfsr_flags_s f,
        input logic [3:0] dens
    );
        sfsr_byte_t b;
        b = `SFSR_RST_BYTE;
        b[`SFSR_BIT_READY] = f.ready; // R7 R5
        b[`SFSR_B1_COMPARE] = f.compare_mismatch; // R8
        b[`SFSR_B1_DENS_HI:`SFSR_B1_DENS_LO] = dens; // R9
        b[`SFSR_B1_PROTECT] = f.protect; // R10
        b[`SFSR_B1_PAGE] = f.binary_page; // R11
        return b;
    endfunction

    function automatic sfsr_byte_t sfsr_compose_two(
        input sfsr_flags_s f
    );
        sfsr_byte_t b;
        b = `SFSR_RST_BYTE;
        b[`SFSR_BIT_READY] = f.ready; // R7 R5
        b[`SFSR_B2_RSV_HI] = 1'b0; // R12
        b[`SFSR_B2_ERROR] = f.erase_program_error_flag; // R13
        b[`SFSR_B2_RSV_LO] = 1'b0; // R12
        b[`SFSR_B2_LOCKDOWN] = f.lockdown_enable_flag; // R14
        b[`SFSR_B2_PS2] = f.buffer_two_program_suspended; // R15
        b[`SFSR_B2_PS1] = f.buffer_one_program_suspended; // R16
        b[`SFSR_B2_ERASE_SUSP] = f.erase_suspended_flag; // R17
        return b;
    endfunction

    // Live level flags
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ready <= 1'b0;
            protect <= 1'b0;
            binary_page <= 1'b0;
            ps2 <= 1'b0;
            ps1 <= 1'b0;
            erase_susp <= 1'b0;
        end else begin
            ready <= ~busy_i; // R7 R2
            protect <= protect_sw_i | protect_hw_i; // R10
            binary_page <= binary_page_i; // R11
            ps2 <= buffer_two_program_suspended_i; // R15
            ps1 <= buffer_one_program_suspended_i; // R16
            erase_susp <= erase_suspended_i; // R17
        end
    end

    // Most recent compare outcome
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            compare_mismatch <= `SFSR_RST_COMPARE;
        end else if (compare_done_i) begin
            compare_mismatch <= compare_mismatch_i; // R8
        end
    end

    // Error of last erase or program
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            erase_program_error_flag <= `SFSR_RST_ERROR;
        end else if (op_done_i) begin
            erase_program_error_flag <= op_fail_i & ~op_abort_i; // R19 R13
        end
    end

    // Lockdown command stays off once disabled
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lockdown_enable_flag <= `SFSR_RST_LOCKDOWN;
        end else if (lockdown_disable_i) begin
            lockdown_enable_flag <= 1'b0; // R14
        end
    end

    always_comb begin
        sys_flags.ready = ready;
        sys_flags.compare_mismatch = compare_mismatch;
        sys_flags.protect = protect;
        sys_flags.binary_page = binary_page;
        sys_flags.erase_program_error_flag = erase_program_error_flag;
        sys_flags.lockdown_enable_flag = lockdown_enable_flag;
        sys_flags.buffer_two_program_suspended = ps2;
        sys_flags.buffer_one_program_suspended = ps1;
        sys_flags.erase_suspended_flag = erase_susp;
    end

    assign flag_vec = sys_flags;

    // Local copy of the status bytes
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_byte_one_o <= `SFSR_RST_BYTE;
            status_byte_two_o <= `SFSR_RST_BYTE;
        end else begin
            status_byte_one_o <= sfsr_compose_one(sys_flags, DENSITY_CODE);
            status_byte_two_o <= sfsr_compose_two(sys_flags);
        end
    end

    // Flags are independent levels; four opcode edges refresh them
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi = gi + 1) begin : g_flag_sync
            always_ff @(posedge sck_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    flag_meta[gi] <= 1'b0;
                    flag_mid[gi] <= 1'b0;
                    flag_late[gi] <= 1'b0;
                end else begin
                    flag_meta[gi] <= flag_vec[gi]; // R5
                    flag_mid[gi] <= flag_meta[gi];
                    flag_late[gi] <= flag_mid[gi];
                end
            end
            // Change taken once second and third stages agree
            always_ff @(posedge sck_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    flag_link[gi] <= 1'b0;
                end else if (flag_mid[gi] == flag_late[gi]) begin
                    flag_link[gi] <= flag_late[gi]; // R5
                end
            end
        end
    endgenerate

    assign link_flags = flag_link;
    assign lnk.byte_one = sfsr_compose_one(link_flags, DENSITY_CODE); // R5
    assign lnk.byte_two = sfsr_compose_two(link_flags); // R5

    assign link_rst = cs_n_i | sys_rst_i; // R6

    sfsr_link_shifter u_shifter (
        .sck_i(sck_i),
        .link_rst_i(link_rst),
        .sys_rst_i(sys_rst_i),
        .si_i(si_i),
        .lnk(lnk.shift)
    );

    assign so_o = lnk.so; // R3
    assign so_oe_n_o = lnk.so_oe_n; // R6

    // Chip select into the system domain
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            read_active_o <= 1'b0;
        end else if (cs_s2 == cs_s3) begin
            read_active_o <= ~cs_s3;
        end
    end

    // Served-read event into the system domain
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= lnk.served_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tog_seen <= 1'b0;
            status_reads_o <= 8'h00;
        end else if ((tog_s2 == tog_s3) && (tog_s3 != tog_seen)) begin
            tog_seen <= tog_s3;
            status_reads_o <= status_reads_o + 8'h01; // R1
        end
    end
endmodule
`default_nettype wire

/* File: verification/sfsr_host_model.sv */
// Purpose: Serial host issuing status reads
// Assumes: Mode 0, 12 ns serial period, data taken on rising edge
// Notes: Serial clock stands low between frames
`timescale 1ns/1ns
`default_nettype none
module sfsr_host_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_n_i
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b1;
    end
    // Pause stretches each low phase for a slow host
    task automatic frame(input logic [7:0] op, input int nout,
            input int pause, output logic [31:0] got, output int oe_cnt);
        got = 32'h0;
        oe_cnt = 0;
        cs_n_o = 1'b0;
        for (int i = 0; i < 8 + nout; i++) begin
            si_o = (i < 8) ? op[7 - i] : ~si_o;
            #(6 + pause);
            sck_o = 1'b1;
            if (i >= 8) begin
                // Released line reads as the inverse of the last value
                got = {got[30:0], so_oe_n_i ? ~so_i : so_i};
                oe_cnt += int'(so_oe_n_i === 1'b0);
            end
            #6;
            sck_o = 1'b0;
        end
        #6;
        cs_n_o = 1'b1;
        si_o = ~si_o;
    endtask
endmodule
`default_nettype wire

/* File: verification/sfsr_status_checker.sv */
// Purpose: Port-level assertions of the status read block
// Assumes: Bound into sfsr_status_top
// Notes: Byte outputs lag flag inputs by two clock_i edges
`timescale 1ns/1ns
`default_nettype none
module sfsr_status_checker
    import sfsr_pkg::*;
#(
    parameter logic [3:0] DENSITY_CODE = 4'h5
)
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic so_oe_n_o,
    input wire logic busy_i,
    input wire logic compare_done_i,
    input wire logic compare_mismatch_i,
    input wire logic op_done_i,
    input wire logic op_fail_i,
    input wire logic op_abort_i,
    input wire logic lockdown_disable_i,
    input wire logic [7:0] status_byte_one_o,
    input wire logic [7:0] status_byte_two_o,
    input wire logic [7:0] status_reads_o
);
    logic [1:0] up;
    logic [3:0] rises;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            up <= 2'h0;
        end else begin
            up <= {up[0], 1'b1};
        end
    end
    // Rising serial edges within the frame
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rises <= 4'h0;
        end else if (rises != 4'h9) begin
            rises <= rises + 4'h1;
        end
    end
    dens_code_a:
    assert property (@(posedge clock_i) disable iff (sys_rst_i)
        up[0] |-> status_byte_one_o[5:2] == DENSITY_CODE)
        else $error("density field wrong");
    ready_flag_a:
    assert property (@(posedge clock_i) disable iff (sys_rst_i)
        up[1] |-> status_byte_one_o[7] == !$past(busy_i, 2)
        && status_byte_two_o[7] == status_byte_one_o[7])
        else $error("ready bit wrong");
    rsv_zero_a:
    assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !status_byte_two_o[6] && !status_byte_two_o[4])
        else $error("reserved bit set");
    err_flag_a:
    assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_done_i |-> ##2 status_byte_two_o[5] ==
        ($past(op_fail_i, 2) && !$past(op_abort_i, 2)))
        else $error("error flag wrong");
    cmp_flag_a:
    assert property (@(posedge clock_i) disable iff (sys_rst_i)
        compare_done_i |-> ##2
        status_byte_one_o[6] == $past(compare_mismatch_i, 2))
        else $error("compare flag wrong");
    lock_clear_a:
    assert property (@(posedge clock_i) disable iff (sys_rst_i)
        lockdown_disable_i |-> ##2 !status_byte_two_o[3])
        else $error("lockdown flag not cleared");
    lock_hold_a:
    assert property (@(posedge clock_i) disable iff (sys_rst_i)
        up[1] && !status_byte_two_o[3] |=> !status_byte_two_o[3])
        else $error("lockdown flag set again");
    oe_order_a:
    assert property (@(posedge sck_i) disable iff (sys_rst_i)
        !so_oe_n_o |-> rises >= 4'h8)
        else $error("output driven before opcode end");
    cs_float_a:
    assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cs_n_i |-> so_oe_n_o)
        else $error("output driven while deselected");
    reads_step_a:
    assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $changed(status_reads_o) |->
        status_reads_o == $past(status_reads_o) + 8'h01)
        else $error("read count step wrong");
    served_c: cover property (@(posedge clock_i) $changed(status_reads_o));
    err_c: cover property (@(posedge clock_i) $rose(status_byte_two_o[5]));
    lock_c: cover property (@(posedge clock_i) $fell(status_byte_two_o[3]));
endmodule
bind sfsr_status_top sfsr_status_checker #(.DENSITY_CODE(DENSITY_CODE)) chk (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sck_i(sck_i),
    .cs_n_i(cs_n_i), .so_oe_n_o(so_oe_n_o), .busy_i(busy_i),
    .compare_done_i(compare_done_i), .compare_mismatch_i(compare_mismatch_i),
    .op_done_i(op_done_i), .op_fail_i(op_fail_i), .op_abort_i(op_abort_i),
    .lockdown_disable_i(lockdown_disable_i),
    .status_byte_one_o(status_byte_one_o),
    .status_byte_two_o(status_byte_two_o), .status_reads_o(status_reads_o));
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench of the status read block
// Assumes: Host model drives the serial link
// Notes: Rows hold flags, byte one and byte two
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [3:0] DENS = 4'h9; // Arbitrary value
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sck, cs_n, si, so, so_oe_n, read_active;
    logic [7:0] fl = 8'h00; // busy cmp psw phw page ps2 ps1 es
    logic cmp_done = 1'b0, op_done = 1'b0, fail = 1'b0, abrt = 1'b0;
    logic lk_dis = 1'b0;
    logic [7:0] b1, b2, reads;
    logic [31:0] got;
    int oe_cnt, n_errors = 0, samples_checked = 0, n_rd = 0;
    logic [23:0] rows [4] = '{24'h00a488, 24'he16609, 24'h1ea78e, 24'h08a588};
    logic [2:0] eseq [4] = '{3'b101, 3'b110, 3'b101, 3'b000};
    always #50 clock_i = ~clock_i;
    sfsr_status_top #(.DENSITY_CODE(DENS)) DUT (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sck_i(sck), .cs_n_i(cs_n),
        .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n), .busy_i(fl[7]),
        .compare_done_i(cmp_done), .compare_mismatch_i(fl[6]),
        .protect_sw_i(fl[5]), .protect_hw_i(fl[4]), .binary_page_i(fl[3]),
        .op_done_i(op_done), .op_fail_i(fail), .op_abort_i(abrt),
        .lockdown_disable_i(lk_dis), .buffer_two_program_suspended_i(fl[2]),
        .buffer_one_program_suspended_i(fl[1]), .erase_suspended_i(fl[0]),
        .status_byte_one_o(b1), .status_byte_two_o(b2),
        .read_active_o(read_active), .status_reads_o(reads));
    sfsr_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
        .so_oe_n_i(so_oe_n));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] op, input int n, input int pause);
        host.frame(op, n, pause, got, oe_cnt);
        if (op == 8'hd7) n_rd++;
        tick(1);
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        n_errors++;
        print_verdict();
    end
    initial begin
        tick(5);
        chk("rst b2", b2, 8'h00);
        chk("rst oe", so_oe_n, 1'b1);
        sys_rst_i = 1'b0;
        for (int r = 0; r < 4; r++) begin
            fl = rows[r][23:16];
            cmp_done = 1'b1;
            tick(1);
            cmp_done = 1'b0;
            tick(4);
            chk("byte1", b1, rows[r][15:8]);
            chk("byte2", b2, rows[r][7:0]);
            rd(8'hd7, 32, r);
            chk("stream", got, {2{rows[r][15:0]}});
            chk("oe", 32'(oe_cnt), 32);
        end
        for (int k = 0; k < 4; k++) begin
            {fail, abrt} = eseq[k][2:1];
            op_done = 1'b1;
            tick(1);
            op_done = 1'b0;
            tick(2);
            chk("error", b2[5], eseq[k][0]);
        end
        fork
            rd(8'hd7, 32, 0);
            begin
                tick(4);
                chk("active", read_active, 1'b1);
            end
        join
        lk_dis = 1'b1;
        tick(1);
        lk_dis = 1'b0;
        tick(8);
        chk("lockdown", b2[3], 1'b0);
        rd(8'hd6, 8, 0);
        chk("refused", 32'(oe_cnt), 0);
        rd(8'hd7, 3, 0);
        chk("partial", got[2:0], 3'b101);
        chk("float", so_oe_n, 1'b1);
        rd(8'hd7, 8, 0);
        chk("restart", got[7:0], 8'ha5);
        fl[7] = 1'b1;
        tick(3);
        rd(8'hd7, 16, 2);
        chk("busy", got[15:0], 16'h2500);
        fl[7] = 1'b0;
        for (int p = 0; p < 40 && got[7] !== 1'b1; p++) rd(8'hd7, 8, 0);
        if (got[7] !== 1'b1) begin
            n_errors++;
            print_verdict();
        end
        chk("ready", got[7:0], 8'ha5);
        tick(5);
        chk("reads", reads, 8'(n_rd));
        chk("active", read_active, 1'b0);
        sys_rst_i = 1'b1;
        tick(1);
        sys_rst_i = 1'b0;
        tick(3);
        chk("rst again", b2, 8'h88);
        print_verdict();
    end
endmodule
`default_nettype wire
